// file: sdpm_pkg.sv
// package for the spi and decoder pin multiplexer
package sdpm_pkg;
  // pull-up register bit positions
  localparam int unsigned PE_PUR_SS_BIT = 7;
  localparam int unsigned PC_PUR_PHA_BIT = 0;
  localparam int unsigned PC_PUR_PHB_BIT = 1;
  // reset values
  localparam logic [7:0] PE_PUR_RST = 8'hff;
  localparam logic [7:0] PC_PUR_RST = 8'hff;
  localparam logic ALT_RST = 1'h0;
  localparam logic GPIO_EN_RST_FULL = 1'h0;
  localparam logic GPIO_EN_RST_REDUCED = 1'h1;

  // pin function selected on a shared pin
  typedef enum logic [1:0] {
    SDPM_FN_PERIPH = 2'b00,
    SDPM_FN_ALT = 2'b01,
    SDPM_FN_GPIO = 2'b11,
    SDPM_FN_NONE = 2'b10
  } sdpm_fn_t;

  // one pad: output, output enable (low drives), pull-up
  typedef struct packed {
    logic dout;
    logic oe_n;
    logic pull_up;
  } sdpm_pad_t;

  // general purpose port control for one pin
  typedef struct packed {
    logic gpio_sel;
    logic dir_out;
    logic dout;
  } sdpm_gpio_t;

  // spi b engine side
  typedef struct packed {
    logic master;
    logic sclk_out;
    logic mosi_out;
  } sdpm_spi_t;
endpackage : sdpm_pkg

// file: sdpm_pin.sv
// one shared pin: function selection, drive and input synchroniser
`timescale 1ns/100ps
module sdpm_pin (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire sdpm_pkg::sdpm_fn_t fn_i,
  input wire logic alt_drive_i,
  input wire logic alt_dout_i,
  input wire logic gpio_dir_out_i,
  input wire logic gpio_dout_i,
  input wire logic pull_up_i,
  input wire logic pad_in_i,
  output sdpm_pkg::sdpm_pad_t pad_o,
  output logic in_sync_o
);
  import sdpm_pkg::*;

  logic meta_ff;
  logic sync_ff;
  sdpm_pad_t pad_ff;
  logic nxt_meta;
  logic nxt_sync;
  sdpm_pad_t nxt_pad;

  always_comb begin
    nxt_meta = pad_in_i;
    nxt_sync = meta_ff;
    nxt_pad.pull_up = pull_up_i;
    nxt_pad.dout = 1'h0;
    nxt_pad.oe_n = 1'h1;
    unique case (fn_i)
      SDPM_FN_ALT: begin
        nxt_pad.dout = alt_dout_i;
        nxt_pad.oe_n = ~alt_drive_i;
      end
      SDPM_FN_GPIO: begin
        nxt_pad.dout = gpio_dout_i;
        nxt_pad.oe_n = ~gpio_dir_out_i;
      end
      SDPM_FN_PERIPH, SDPM_FN_NONE: begin
        nxt_pad.dout = 1'h0;
        nxt_pad.oe_n = 1'h1;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      // pulled-up pin idles high; a low reset value would fake a select
      meta_ff <= 1'h1;
      sync_ff <= 1'h1;
      pad_ff <= '{dout: 1'h0, oe_n: 1'h1, pull_up: 1'h1};
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      pad_ff <= nxt_pad;
    end
  end

  assign pad_o = pad_ff;
  assign in_sync_o = sync_ff;
endmodule : sdpm_pin

// file: sdpm_mux.sv
// pin multiplexer for spi a select and decoder b phase pins
// Operation
// - slave select marks transfer for spi a
// - after reset pin routes spi a select
// - select pull-up on in reset, bit7 disables
// - each gpio pin has own direction
// - spi b clock drives if master, else input
// - phase a alternate bit selects spi b clock
// - phase b alternate bit selects spi b data
// - master data leads latch edge by half; mux passes spi b mosi_out through as the engine drives it
// - full variant resets pins to decoder inputs
// - phase pull-ups on in reset, bits0/1 disable
`timescale 1ns/100ps
module sdpm_mux #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] port_e_pullup_enable_i,
  input wire logic [7:0] port_c_pullup_enable_i,
  input wire logic phase_a_alternate_select_i,
  input wire logic phase_b_alternate_select_i,
  input wire logic pullup_write_i,
  input wire sdpm_pkg::sdpm_gpio_t port_e_bit_seven_i,
  input wire sdpm_pkg::sdpm_gpio_t port_c_bit_zero_i,
  input wire sdpm_pkg::sdpm_gpio_t port_c_bit_one_i,
  input wire sdpm_pkg::sdpm_spi_t spi_b_i,
  input wire logic timer_b_channel_zero_i,
  input wire logic timer_b_channel_zero_oe_i,
  input wire logic timer_b_channel_one_i,
  input wire logic timer_b_channel_one_oe_i,
  input wire logic timer_b_sel_i,
  input wire logic ss_pad_i,
  input wire logic pha_pad_i,
  input wire logic phb_pad_i,
  output sdpm_pkg::sdpm_pad_t ss_pad_o,
  output sdpm_pkg::sdpm_pad_t pha_pad_o,
  output sdpm_pkg::sdpm_pad_t phb_pad_o,
  output logic spi_a_slave_select_n_o,
  output logic decoder_b_phase_a_input_o,
  output logic decoder_b_phase_b_input_o,
  output logic spi_b_serial_clock_o,
  output logic spi_b_master_out_data_o,
  output logic port_e_bit_seven_o,
  output logic port_c_bit_zero_o,
  output logic port_c_bit_one_o,
  output logic timer_b_channel_zero_o,
  output logic timer_b_channel_one_o,
  output logic configured_o
);
  import sdpm_pkg::*;

  // software visible configuration, held here
  logic [7:0] pe_pur_ff;
  logic [7:0] pc_pur_ff;
  logic cfg_done_ff;
  logic [7:0] nxt_pe_pur;
  logic [7:0] nxt_pc_pur;
  logic nxt_cfg_done;

  always_comb begin
    nxt_pe_pur = pe_pur_ff;
    nxt_pc_pur = pc_pur_ff;
    nxt_cfg_done = cfg_done_ff;
    if (pullup_write_i) begin
      nxt_pe_pur = port_e_pullup_enable_i;
      nxt_pc_pur = port_c_pullup_enable_i;
    end
    // reduced variant stays unrouted until software touches config
    if (pullup_write_i || port_c_bit_zero_i.gpio_sel || port_c_bit_one_i.gpio_sel ||
        phase_a_alternate_select_i || phase_b_alternate_select_i) begin
      nxt_cfg_done = 1'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pe_pur_ff <= PE_PUR_RST;
      pc_pur_ff <= PC_PUR_RST;
      cfg_done_ff <= FULL_VARIANT ? 1'h1 : 1'h0;
    end else begin
      pe_pur_ff <= nxt_pe_pur;
      pc_pur_ff <= nxt_pc_pur;
      cfg_done_ff <= nxt_cfg_done;
    end
  end

  // function selection per pin
  sdpm_fn_t ss_fn;
  sdpm_fn_t pha_fn;
  sdpm_fn_t phb_fn;
  logic pha_alt_drive;
  logic pha_alt_dout;
  logic phb_alt_drive;
  logic phb_alt_dout;

  always_comb begin
    // gpio claim outranks alternate; alternate outranks decoder
    ss_fn = port_e_bit_seven_i.gpio_sel ? SDPM_FN_GPIO : SDPM_FN_PERIPH;
    if (!cfg_done_ff) begin
      pha_fn = SDPM_FN_NONE;
      phb_fn = SDPM_FN_NONE;
    end else begin
      if (port_c_bit_zero_i.gpio_sel) begin
        pha_fn = SDPM_FN_GPIO;
      end else if (phase_a_alternate_select_i || timer_b_sel_i) begin
        pha_fn = SDPM_FN_ALT;
      end else begin
        pha_fn = SDPM_FN_PERIPH;
      end
      if (port_c_bit_one_i.gpio_sel) begin
        phb_fn = SDPM_FN_GPIO;
      end else if (phase_b_alternate_select_i || timer_b_sel_i) begin
        phb_fn = SDPM_FN_ALT;
      end else begin
        phb_fn = SDPM_FN_PERIPH;
      end
    end
    // spi alternate wins over timer when both asked
    if (phase_a_alternate_select_i) begin
      pha_alt_drive = spi_b_i.master;
      pha_alt_dout = spi_b_i.sclk_out;
    end else begin
      pha_alt_drive = timer_b_channel_zero_oe_i;
      pha_alt_dout = timer_b_channel_zero_i;
    end
    if (phase_b_alternate_select_i) begin
      // timing of data against clock is owned by the spi engine
      phb_alt_drive = spi_b_i.master;
      phb_alt_dout = spi_b_i.mosi_out;
    end else begin
      phb_alt_drive = timer_b_channel_one_oe_i;
      phb_alt_dout = timer_b_channel_one_i;
    end
  end

  logic ss_sync;
  logic pha_sync;
  logic phb_sync;

  sdpm_pin u_ss_pin (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .fn_i(ss_fn),
    .alt_drive_i(1'h0),
    .alt_dout_i(1'h0),
    .gpio_dir_out_i(port_e_bit_seven_i.dir_out),
    .gpio_dout_i(port_e_bit_seven_i.dout),
    .pull_up_i(pe_pur_ff[PE_PUR_SS_BIT]),
    .pad_in_i(ss_pad_i),
    .pad_o(ss_pad_o),
    .in_sync_o(ss_sync)
  );

  sdpm_pin u_pha_pin (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .fn_i(pha_fn),
    .alt_drive_i(pha_alt_drive),
    .alt_dout_i(pha_alt_dout),
    .gpio_dir_out_i(port_c_bit_zero_i.dir_out),
    .gpio_dout_i(port_c_bit_zero_i.dout),
    .pull_up_i(pc_pur_ff[PC_PUR_PHA_BIT]),
    .pad_in_i(pha_pad_i),
    .pad_o(pha_pad_o),
    .in_sync_o(pha_sync)
  );

  sdpm_pin u_phb_pin (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .fn_i(phb_fn),
    .alt_drive_i(phb_alt_drive),
    .alt_dout_i(phb_alt_dout),
    .gpio_dir_out_i(port_c_bit_one_i.dir_out),
    .gpio_dout_i(port_c_bit_one_i.dout),
    .pull_up_i(pc_pur_ff[PC_PUR_PHB_BIT]),
    .pad_in_i(phb_pad_i),
    .pad_o(phb_pad_o),
    .in_sync_o(phb_sync)
  );

  // inputs routed to the internal consumers
  typedef struct packed {
    logic ss_n;
    logic pha;
    logic phb;
    logic sclk;
    logic mosi;
    logic pe7;
    logic pc0;
    logic pc1;
    logic tmr0;
    logic tmr1;
  } sdpm_route_t;

  sdpm_route_t route_ff;
  sdpm_route_t nxt_route;

  always_comb begin
    // unselected consumer sees idle level: select high, decoder, spi and timer low; gpio inputs always see the pad
    nxt_route.ss_n = (ss_fn == SDPM_FN_PERIPH) ? ss_sync : 1'h1;
    nxt_route.pha = (pha_fn == SDPM_FN_PERIPH) ? pha_sync : 1'h0;
    nxt_route.phb = (phb_fn == SDPM_FN_PERIPH) ? phb_sync : 1'h0;
    nxt_route.sclk = (pha_fn == SDPM_FN_ALT && phase_a_alternate_select_i && !spi_b_i.master) ?
                     pha_sync : 1'h0;
    nxt_route.mosi = (phb_fn == SDPM_FN_ALT && phase_b_alternate_select_i && !spi_b_i.master) ?
                     phb_sync : 1'h0;
    nxt_route.pe7 = ss_sync;
    nxt_route.pc0 = pha_sync;
    nxt_route.pc1 = phb_sync;
    nxt_route.tmr0 = (pha_fn == SDPM_FN_ALT && !phase_a_alternate_select_i) ? pha_sync : 1'h0;
    nxt_route.tmr1 = (phb_fn == SDPM_FN_ALT && !phase_b_alternate_select_i) ? phb_sync : 1'h0;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      route_ff <= '{ss_n: 1'h1, default: 1'h0};
    end else begin
      route_ff <= nxt_route;
    end
  end

  assign spi_a_slave_select_n_o = route_ff.ss_n;
  assign decoder_b_phase_a_input_o = route_ff.pha;
  assign decoder_b_phase_b_input_o = route_ff.phb;
  assign spi_b_serial_clock_o = route_ff.sclk;
  assign spi_b_master_out_data_o = route_ff.mosi;
  assign port_e_bit_seven_o = route_ff.pe7;
  assign port_c_bit_zero_o = route_ff.pc0;
  assign port_c_bit_one_o = route_ff.pc1;
  assign timer_b_channel_zero_o = route_ff.tmr0;
  assign timer_b_channel_one_o = route_ff.tmr1;
  assign configured_o = cfg_done_ff;

  // checks
  sequence ss_low_s;
    !ss_pad_i && !port_e_bit_seven_i.gpio_sel;
  endsequence

  ss_route_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ss_low_s [*4] |-> !spi_a_slave_select_n_o)
    else $error("slave select not routed");
  // pull-up reaches the pad two edges after the strobe: register, then pad flop
  ss_pullup_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    pullup_write_i |=> ##1 ss_pad_o.pull_up == $past(port_e_pullup_enable_i[PE_PUR_SS_BIT], 2))
    else $error("select pull-up wrong");
  ss_release_a: assert property (@(posedge core_clk_i)
    $rose(nrst_i) |-> ss_pad_o.oe_n && spi_a_slave_select_n_o)
    else $error("select pin not input after reset");
  gpio_dir_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (port_c_bit_zero_i.gpio_sel && cfg_done_ff) |=> pha_pad_o.oe_n == !$past(port_c_bit_zero_i.dir_out))
    else $error("gpio direction wrong");
  sclk_drive_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (cfg_done_ff && !port_c_bit_zero_i.gpio_sel && phase_a_alternate_select_i && spi_b_i.master)
    |=> !pha_pad_o.oe_n && pha_pad_o.dout == $past(spi_b_i.sclk_out))
    else $error("spi clock not driven");
  phb_alt_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (cfg_done_ff && !port_c_bit_one_i.gpio_sel && phase_b_alternate_select_i && !spi_b_i.master)
    |=> phb_pad_o.oe_n)
    else $error("mosi slave driving");
  pc_pullup_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    pullup_write_i |=> ##1 pha_pad_o.pull_up == $past(port_c_pullup_enable_i[PC_PUR_PHA_BIT], 2) &&
    phb_pad_o.pull_up == $past(port_c_pullup_enable_i[PC_PUR_PHB_BIT], 2))
    else $error("port c pull-up wrong");
  dec_keep_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (cfg_done_ff && !port_c_bit_zero_i.gpio_sel && !phase_a_alternate_select_i && !timer_b_sel_i)
    |=> pha_pad_o.oe_n)
    else $error("decoder pin driven");

  // decoder input follows the pad three edges later: two sync flops, one route flop
  sequence pha_high_s;
    pha_pad_i && cfg_done_ff && !port_c_bit_zero_i.gpio_sel &&
    !phase_a_alternate_select_i && !timer_b_sel_i;
  endsequence
  dec_route_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    pha_high_s [*4] |-> decoder_b_phase_a_input_o)
    else $error("decoder phase a not routed");
  pins_unrouted_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !cfg_done_ff |=> pha_pad_o.oe_n && phb_pad_o.oe_n && !decoder_b_phase_a_input_o &&
    !decoder_b_phase_b_input_o)
    else $error("reduced pins routed before setup");
  ss_gpio_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    port_e_bit_seven_i.gpio_sel |=> ss_pad_o.oe_n == !$past(port_e_bit_seven_i.dir_out) &&
    ss_pad_o.dout == $past(port_e_bit_seven_i.dout))
    else $error("select pin gpio drive wrong");
  pha_alt_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (cfg_done_ff && !port_c_bit_zero_i.gpio_sel && phase_a_alternate_select_i)
    |=> pha_pad_o.oe_n == !$past(spi_b_i.master))
    else $error("phase a pin not spi clock");
  sclk_in_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (cfg_done_ff && !port_c_bit_zero_i.gpio_sel && phase_a_alternate_select_i && !spi_b_i.master)
    |=> pha_pad_o.oe_n)
    else $error("slave spi clock driven");
  mosi_drive_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (cfg_done_ff && !port_c_bit_one_i.gpio_sel && phase_b_alternate_select_i && spi_b_i.master)
    |=> !phb_pad_o.oe_n && phb_pad_o.dout == $past(spi_b_i.mosi_out))
    else $error("master data not driven");
  dec_b_keep_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (cfg_done_ff && !port_c_bit_one_i.gpio_sel && !phase_b_alternate_select_i && !timer_b_sel_i)
    |=> phb_pad_o.oe_n)
    else $error("decoder phase b pin driven");
endmodule : sdpm_mux

// file: sdpm_pad_model.sv
// partner model: one external pad with its peer, pull-up and floating level
`timescale 1ns/100ps
module sdpm_pad_model (
  input wire logic core_clk_i,
  input wire sdpm_pkg::sdpm_pad_t pad_i,
  input wire logic ext_en_i,
  input wire logic ext_val_i,
  output logic level_o
);
  import sdpm_pkg::*;
  // floating pin toggles so a stale value never reads as valid
  logic float_ff = 1'h0;
  always_ff @(posedge core_clk_i) begin
    float_ff <= ~float_ff;
  end
  // device drive wins; an enabled peer drives select or phase lines otherwise, else pull-up or floating level
  assign level_o = !pad_i.oe_n ? pad_i.dout :
                   ext_en_i ? ext_val_i :
                   pad_i.pull_up ? 1'h1 : float_ff;
endmodule : sdpm_pad_model

// file: sdpm_mux_tb.sv
// self-checking testbench for the spi and decoder pin multiplexer
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, a, b); end end
module sdpm_mux_tb;
  import sdpm_pkg::*;
  logic core_clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic [7:0] pe_pur = 8'hff;
  logic [7:0] pc_pur = 8'hff;
  logic alt_a = 1'h0;
  logic alt_b = 1'h0;
  logic pur_wr = 1'h0;
  sdpm_gpio_t ge7 = '0;
  sdpm_gpio_t gc0 = '0;
  sdpm_gpio_t gc1 = '0;
  sdpm_spi_t spi = '0;
  logic tb_sel = 1'h0;
  logic [2:0] ext_en = 3'h0;
  logic [2:0] ext_val = 3'h0;
  logic [2:0] lvl;
  sdpm_pad_t ss_pad;
  sdpm_pad_t pha_pad;
  sdpm_pad_t phb_pad;
  logic ss_n, dec_a, dec_b, sclk, mosi, pe7, pc0, pc1, tmr0, tmr1, cfg;
  sdpm_pad_t red_pha;
  logic red_dec, red_cfg;
  int fails = 0;
  int check_count = 0;

  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end

  sdpm_mux u_sdpm_mux (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .port_e_pullup_enable_i(pe_pur), .port_c_pullup_enable_i(pc_pur),
    .phase_a_alternate_select_i(alt_a), .phase_b_alternate_select_i(alt_b),
    .pullup_write_i(pur_wr), .port_e_bit_seven_i(ge7), .port_c_bit_zero_i(gc0),
    .port_c_bit_one_i(gc1), .spi_b_i(spi), .timer_b_channel_zero_i(1'h1),
    .timer_b_channel_zero_oe_i(1'h1), .timer_b_channel_one_i(1'h0),
    .timer_b_channel_one_oe_i(1'h1), .timer_b_sel_i(tb_sel), .ss_pad_i(lvl[0]),
    .pha_pad_i(lvl[1]), .phb_pad_i(lvl[2]), .ss_pad_o(ss_pad), .pha_pad_o(pha_pad),
    .phb_pad_o(phb_pad), .spi_a_slave_select_n_o(ss_n), .decoder_b_phase_a_input_o(dec_a),
    .decoder_b_phase_b_input_o(dec_b), .spi_b_serial_clock_o(sclk),
    .spi_b_master_out_data_o(mosi), .port_e_bit_seven_o(pe7), .port_c_bit_zero_o(pc0),
    .port_c_bit_one_o(pc1), .timer_b_channel_zero_o(tmr0), .timer_b_channel_one_o(tmr1),
    .configured_o(cfg));
  // reduced variant shares every input; only its routing state is judged
  sdpm_mux #(.FULL_VARIANT(1'b0)) u_sdpm_mux_red (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .port_e_pullup_enable_i(pe_pur), .port_c_pullup_enable_i(pc_pur),
    .phase_a_alternate_select_i(alt_a), .phase_b_alternate_select_i(alt_b),
    .pullup_write_i(pur_wr), .port_e_bit_seven_i(ge7), .port_c_bit_zero_i(gc0),
    .port_c_bit_one_i(gc1), .spi_b_i(spi), .timer_b_channel_zero_i(1'h1),
    .timer_b_channel_zero_oe_i(1'h1), .timer_b_channel_one_i(1'h0),
    .timer_b_channel_one_oe_i(1'h1), .timer_b_sel_i(tb_sel), .ss_pad_i(lvl[0]),
    .pha_pad_i(lvl[1]), .phb_pad_i(lvl[2]), .ss_pad_o(), .pha_pad_o(red_pha),
    .phb_pad_o(), .spi_a_slave_select_n_o(), .decoder_b_phase_a_input_o(red_dec),
    .decoder_b_phase_b_input_o(), .spi_b_serial_clock_o(), .spi_b_master_out_data_o(),
    .port_e_bit_seven_o(), .port_c_bit_zero_o(), .port_c_bit_one_o(), .timer_b_channel_zero_o(),
    .timer_b_channel_one_o(), .configured_o(red_cfg));
  sdpm_pad_model u_ss (.core_clk_i(core_clk_i), .pad_i(ss_pad), .ext_en_i(ext_en[0]),
    .ext_val_i(ext_val[0]), .level_o(lvl[0]));
  sdpm_pad_model u_pha (.core_clk_i(core_clk_i), .pad_i(pha_pad), .ext_en_i(ext_en[1]),
    .ext_val_i(ext_val[1]), .level_o(lvl[1]));
  sdpm_pad_model u_phb (.core_clk_i(core_clk_i), .pad_i(phb_pad), .ext_en_i(ext_en[2]),
    .ext_val_i(ext_val[2]), .level_o(lvl[2]));

  // fixed waits: pads answer in 1 cycle, routed inputs within 3 (+1 for drive)
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc

  task automatic t_reset();
    `CHK(ss_pad.oe_n, 1'h1)
    `CHK(ss_pad.pull_up, 1'h1)
    `CHK({pha_pad.pull_up, phb_pad.pull_up}, 2'h3)
    `CHK(cfg, 1'h1)
    `CHK({red_cfg, red_pha.oe_n}, 2'h1)
    ext_en = 3'h7;
    ext_val = 3'h6;
    cyc(5);
    `CHK(ss_n, 1'h0)
    `CHK({dec_b, dec_a}, 2'h3)
    `CHK(red_dec, 1'h0)
    ext_val = 3'h1;
    cyc(5);
    `CHK(ss_n, 1'h1)
    `CHK({dec_b, dec_a}, 2'h0)
    $display("test reset done");
  endtask : t_reset

  task automatic t_pullup();
    pe_pur = 8'h7f;
    pc_pur = 8'hfc;
    pur_wr = 1'h1;
    cyc(1);
    pur_wr = 1'h0;
    cyc(1);
    `CHK(ss_pad.pull_up, 1'h0)
    `CHK({pha_pad.pull_up, phb_pad.pull_up}, 2'h0)
    `CHK(red_cfg, 1'h1)
    pc_pur = 8'hfe;
    pur_wr = 1'h1;
    cyc(1);
    pur_wr = 1'h0;
    cyc(1);
    `CHK({pha_pad.pull_up, phb_pad.pull_up}, 2'h1)
    $display("test pullup done");
  endtask : t_pullup

  task automatic t_gpio();
    gc0 = '{gpio_sel: 1'h1, dir_out: 1'h1, dout: 1'h1};
    gc1 = '{gpio_sel: 1'h1, dir_out: 1'h0, dout: 1'h1};
    ge7 = '{gpio_sel: 1'h1, dir_out: 1'h0, dout: 1'h0};
    ext_en = 3'h5;
    ext_val = 3'h4;
    cyc(5);
    `CHK({pha_pad.oe_n, pha_pad.dout}, 2'h1)
    `CHK(phb_pad.oe_n, 1'h1)
    `CHK({pe7, pc1, pc0}, 3'h3)
    `CHK(ss_n, 1'h1)
    gc0 = '0;
    gc1 = '0;
    ge7 = '0;
    ext_val = 3'h7;
    cyc(5);
    `CHK({pha_pad.oe_n, dec_b}, 2'h3)
    $display("test gpio done");
  endtask : t_gpio

  task automatic t_alt();
    tb_sel = 1'h1;
    ext_en = 3'h0;
    cyc(2);
    `CHK({pha_pad.oe_n, pha_pad.dout, phb_pad.oe_n, phb_pad.dout}, 4'h4)
    cyc(3);
    `CHK({tmr0, tmr1}, 2'h2)
    alt_a = 1'h1;
    alt_b = 1'h1;
    spi = '{master: 1'h1, sclk_out: 1'h1, mosi_out: 1'h0};
    cyc(2);
    `CHK({pha_pad.oe_n, pha_pad.dout}, 2'h1)
    `CHK({phb_pad.oe_n, phb_pad.dout}, 2'h0)
    spi = '{master: 1'h1, sclk_out: 1'h0, mosi_out: 1'h1};
    cyc(2);
    `CHK({pha_pad.dout, phb_pad.dout}, 2'h1)
    spi = '{master: 1'h0, sclk_out: 1'h1, mosi_out: 1'h0};
    ext_en = 3'h6;
    ext_val = 3'h6;
    cyc(5);
    `CHK({pha_pad.oe_n, phb_pad.oe_n}, 2'h3)
    `CHK({sclk, mosi}, 2'h3)
    alt_a = 1'h0;
    alt_b = 1'h0;
    tb_sel = 1'h0;
    $display("test alternate done");
  endtask : t_alt

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  initial begin
    cyc(3);
    nrst_i = 1'h1;
    cyc(1);
    t_reset();
    t_pullup();
    t_gpio();
    t_alt();
    conclude();
  end
endmodule : sdpm_mux_tb
